// ==== core/pisd_pkg.sv ====
// Purpose: Shared constants for the event flag and pin function bank.
// Assumes: 50 MHz device clock, 16-bit register words.
// Notes: Offsets are the register indices as used on the access port.
package pisd_pkg;

   // ***********************************************************
   // Register map
   // ***********************************************************
   localparam logic [15:0] PISD_ADDR_EVENT_FLAGS = 16'h0011;
   localparam logic [15:0] PISD_ADDR_PIN_CONFIG = 16'h0012;
   localparam logic [15:0] PISD_EVENT_FLAGS_RST = 16'h8000;
   localparam logic [15:0] PISD_PIN_CONFIG_RST = 16'h6060;
   localparam int PISD_EVT_W = 6;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int PISD_RESET_FLAG_BIT = 15;
   localparam int PISD_COLLISION_BIT = 5;
   localparam int PISD_PLCA_RECOVERY_BIT = 4;
   localparam int PISD_REMOTE_JABBER_BIT = 3;
   localparam int PISD_LOCAL_JABBER_BIT = 2;
   localparam int PISD_PLCA_STATE_BIT = 1;
   localparam int PISD_LINK_CHANGE_BIT = 0;
   localparam int PISD_PIN1_SLEW_BIT = 15;
   localparam int PISD_PIN1_PULL_EN_BIT = 14;
   localparam int PISD_PIN1_PULL_DN_BIT = 13;
   localparam int PISD_PIN1_FUNC_LSB = 9;
   localparam int PISD_PIN1_VALUE_BIT = 8;
   localparam int PISD_PIN0_SLEW_BIT = 7;
   localparam int PISD_PIN0_PULL_EN_BIT = 6;
   localparam int PISD_PIN0_PULL_DN_BIT = 5;
   localparam int PISD_PIN0_FUNC_LSB = 1;
   localparam int PISD_PIN0_VALUE_BIT = 0;

   // ***********************************************************
   // Pin function codes
   // ***********************************************************
   localparam logic [3:0] PISD_FN_DISABLE = 4'h0;
   localparam logic [3:0] PISD_FN_GPIO = 4'h1;
   localparam logic [3:0] PISD_FN_SFD_TX = 4'h2;
   localparam logic [3:0] PISD_FN_SFD_RX = 4'h3;
   localparam logic [3:0] PISD_FN_LED_LINK = 4'h4;
   localparam logic [3:0] PISD_FN_LED_PLCA = 4'h5;
   localparam logic [3:0] PISD_FN_LED_TX = 4'h6;
   localparam logic [3:0] PISD_FN_LED_RX = 4'h7;
   localparam logic [3:0] PISD_FN_CLOCK_OUT = 4'h8;
   localparam logic [3:0] PISD_FN_SFD_BOTH = 4'hb;
   localparam logic [3:0] PISD_FN_LED_BOTH = 4'hf;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int PISD_CLK_PERIOD_NS = 20;
   localparam int PISD_SFD_PULSE_NS = 160;
   localparam int PISD_SFD_PULSE_CYCLES =
      (PISD_SFD_PULSE_NS + PISD_CLK_PERIOD_NS - 1) / PISD_CLK_PERIOD_NS;

endpackage : pisd_pkg

// ==== core/pisd_pulse_stretch.sv ====
// Purpose: Widens a one-cycle frame delimiter strobe into a visible pulse.
// Assumes: Trigger is on the device clock.
// Notes: A trigger during a pulse restarts the full length.
module pisd_pulse_stretch #(
   parameter int LEN = pisd_pkg::PISD_SFD_PULSE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic trig_i,
   output logic active_o
);
   import pisd_pkg::*;

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;

   // The counter is eight bits wide, so longer pulses cannot be served.
   if (LEN < 1 || LEN > 255) begin : g_len_check
      $error("pulse length out of range");
   end

   always_comb begin
      if (trig_i) begin
         cnt_next = 8'(LEN);
      end else if (cnt_reg != 8'h00) begin
         cnt_next = cnt_reg - 8'h01;
      end else begin
         cnt_next = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign active_o = (cnt_reg != 8'h00);

endmodule : pisd_pulse_stretch

// ==== core/pisd_pin_func.sv ====
// Purpose: Selects what one general pin shows from its function code.
// Assumes: All status inputs are on the device clock.
// Notes: Purely combinational; the caller registers the result.
module pisd_pin_func (
   input wire logic [3:0] func_i,
   input wire logic value_i,
   input wire logic sfd_tx_i,
   input wire logic sfd_rx_i,
   input wire logic link_on_i,
   input wire logic plca_up_i,
   input wire logic tx_act_i,
   input wire logic rx_act_i,
   input wire logic clk_half_i,
   output logic drive_o,
   output logic level_o
);
   import pisd_pkg::*;

   logic active;

   always_comb begin
      drive_o = 1'b1;
      active = 1'b0;
      case (func_i)
         PISD_FN_SFD_TX: active = sfd_tx_i;
         PISD_FN_SFD_RX: active = sfd_rx_i;
         PISD_FN_SFD_BOTH: active = sfd_tx_i | sfd_rx_i;
         PISD_FN_LED_LINK: active = link_on_i;
         PISD_FN_LED_PLCA: active = plca_up_i;
         PISD_FN_LED_TX: active = tx_act_i;
         PISD_FN_LED_RX: active = rx_act_i;
         PISD_FN_LED_BOTH: active = tx_act_i | rx_act_i;
         PISD_FN_CLOCK_OUT: active = clk_half_i;
         PISD_FN_GPIO: active = value_i;
         default: drive_o = 1'b0;
      endcase
      // GPIO shows the value bit as is; every other function uses it as
      // the active level.
      if (func_i == PISD_FN_GPIO) begin
         level_o = value_i;
      end else begin
         level_o = value_i ? active : ~active;
      end
   end

endmodule : pisd_pin_func

// ==== core/pisd_bank.sv ====
// Purpose: Event flag register and general pin configuration register.
// Assumes: Events and register strobes come from logic on MCLK_I.
// Notes: Read data appears on the edge after the read strobe.
// Notes on behaviour
// - Event flags latch on their event and clear when the host reads them.
// - Bit 15 is set by any hardware reset; register leaves reset at 0x8000.
// - Bit 15 never raises the PHY interrupt.
// - Writing one clears bit 15; only a later reset sets it again.
// - Bit 5 latches on a physical collision.
// - Bit 4 latches on a PLCA recovery.
// - Bit 3 latches on a remote jabber fault.
// - Bit 2 latches on local jabber detection.
// - Bit 1 latches on a PLCA status change.
// - Bit 0 latches on a link status change.
// - A flag raises the interrupt only while its enable bit is one.
// - Slew bits 15 and 7 select slow edges when one; reset zero.
// - Pull enable bits 14 and 6 turn the pull on; reset one.
// - Pull direction bits 13 and 5 select pull-down when one; reset one.
// - Function code 0x0 puts the pin in high impedance; reset state.
// - Code 0x1 drives the pin with its value bit.
// - In non-GPIO functions the value bit sets polarity, one active high.
// - Code 0x2 pulses on transmit delimiter, 0x3 on receive delimiter.
// - Code 0xB pulses on a delimiter in either direction.
// - Code 0x4 lights while link is enabled and up.
// - Code 0x5 lights while PLCA status is up.
// - Codes 0x6, 0x7, 0xF show transmit, receive and both activity.
module pisd_bank (
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic [15:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [15:0] REG_WDATA_I,
   output logic [15:0] REG_RDATA_O,
   input wire logic EVT_COLLISION_I,
   input wire logic EVT_PLCA_RECOVERY_I,
   input wire logic EVT_REMOTE_JABBER_I,
   input wire logic EVT_LOCAL_JABBER_I,
   input wire logic EVT_PLCA_STATE_I,
   input wire logic EVT_LINK_CHANGE_I,
   input wire logic [pisd_pkg::PISD_EVT_W-1:0] IRQ_ENABLE_I,
   output logic PHY_INTERRUPT_O,
   input wire logic SFD_TX_I,
   input wire logic SFD_RX_I,
   input wire logic LINK_ENABLE_I,
   input wire logic LINK_UP_I,
   input wire logic PLCA_UP_I,
   input wire logic TX_ACTIVE_I,
   input wire logic RX_ACTIVE_I,
   output logic [1:0] PIN_OUT_O,
   output logic [1:0] PIN_OE_O,
   output logic [1:0] PIN_SLEW_SLOW_O,
   output logic [1:0] PIN_PULL_EN_O,
   output logic [1:0] PIN_PULL_DOWN_O
);
   import pisd_pkg::*;

   // ***********************************************************
   // Register access
   // ***********************************************************
   logic [15:0] event_flags_reg;
   logic [15:0] event_flags_next;
   logic [15:0] pin_config_reg;
   logic [15:0] pin_config_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic irq_reg;
   logic irq_next;
   logic [PISD_EVT_W-1:0] event_in;
   logic flags_read;
   logic flags_write;
   logic config_write;

   assign event_in[PISD_COLLISION_BIT] = EVT_COLLISION_I;
   assign event_in[PISD_PLCA_RECOVERY_BIT] = EVT_PLCA_RECOVERY_I;
   assign event_in[PISD_REMOTE_JABBER_BIT] = EVT_REMOTE_JABBER_I;
   assign event_in[PISD_LOCAL_JABBER_BIT] = EVT_LOCAL_JABBER_I;
   assign event_in[PISD_PLCA_STATE_BIT] = EVT_PLCA_STATE_I;
   assign event_in[PISD_LINK_CHANGE_BIT] = EVT_LINK_CHANGE_I;

   assign flags_read = REG_RD_I && (REG_ADDR_I == PISD_ADDR_EVENT_FLAGS);
   assign flags_write = REG_WR_I && (REG_ADDR_I == PISD_ADDR_EVENT_FLAGS);
   assign config_write = REG_WR_I && (REG_ADDR_I == PISD_ADDR_PIN_CONFIG);

   always_comb begin
      event_flags_next = event_flags_reg;
      // An event in the cycle of the read is kept, so none is lost.
      if (flags_read) begin
         event_flags_next[PISD_EVT_W-1:0] = '0;
      end
      event_flags_next[PISD_EVT_W-1:0] =
         event_flags_next[PISD_EVT_W-1:0] | event_in;
      // The reset flag has no set path besides reset itself.
      if (flags_write && REG_WDATA_I[PISD_RESET_FLAG_BIT]) begin
         event_flags_next[PISD_RESET_FLAG_BIT] = 1'b0;
      end
      event_flags_next[14:PISD_EVT_W] = '0;
   end

   always_comb begin
      pin_config_next = pin_config_reg;
      if (config_write) begin
         pin_config_next = REG_WDATA_I;
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            PISD_ADDR_EVENT_FLAGS: rdata_next = event_flags_reg;
            PISD_ADDR_PIN_CONFIG: rdata_next = pin_config_reg;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // Only the six event flags reach the interrupt; bit 15 is left out.
   assign irq_next =
      |(event_flags_reg[PISD_EVT_W-1:0] & IRQ_ENABLE_I);

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         event_flags_reg <= PISD_EVENT_FLAGS_RST;
         pin_config_reg <= PISD_PIN_CONFIG_RST;
         rdata_reg <= 16'h0000;
         irq_reg <= 1'b0;
      end else begin
         event_flags_reg <= event_flags_next;
         pin_config_reg <= pin_config_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign REG_RDATA_O = rdata_reg;
   assign PHY_INTERRUPT_O = irq_reg;

   // ***********************************************************
   // Pin configuration fields
   // ***********************************************************
   logic [3:0] pin1_function_select;
   logic [3:0] pin0_function_select;
   logic pin1_value_polarity;
   logic pin0_value_polarity;
   logic [3:0] func_sel [2];
   logic [1:0] value_sel;

   assign pin1_function_select =
      pin_config_reg[PISD_PIN1_FUNC_LSB+:4];
   assign pin0_function_select =
      pin_config_reg[PISD_PIN0_FUNC_LSB+:4];
   assign pin1_value_polarity = pin_config_reg[PISD_PIN1_VALUE_BIT];
   assign pin0_value_polarity = pin_config_reg[PISD_PIN0_VALUE_BIT];
   assign func_sel[0] = pin0_function_select;
   assign func_sel[1] = pin1_function_select;
   assign value_sel = {pin1_value_polarity, pin0_value_polarity};

   assign PIN_SLEW_SLOW_O = {pin_config_reg[PISD_PIN1_SLEW_BIT],
      pin_config_reg[PISD_PIN0_SLEW_BIT]};
   assign PIN_PULL_EN_O = {pin_config_reg[PISD_PIN1_PULL_EN_BIT],
      pin_config_reg[PISD_PIN0_PULL_EN_BIT]};
   // The direction is only meaningful while the pull is on.
   assign PIN_PULL_DOWN_O = {pin_config_reg[PISD_PIN1_PULL_DN_BIT],
      pin_config_reg[PISD_PIN0_PULL_DN_BIT]};

   // ***********************************************************
   // Pin drivers
   // ***********************************************************
   logic sfd_tx_act;
   logic sfd_rx_act;
   logic clk_half_reg;
   logic clk_half_next;
   logic [1:0] pin_out_reg;
   logic [1:0] pin_out_next;
   logic [1:0] pin_oe_reg;
   logic [1:0] pin_oe_next;
   logic [1:0] drive;
   logic [1:0] level;

   // Delimiter strobes last one cycle, too short to see on a pin.
   pisd_pulse_stretch #(
      .LEN(PISD_SFD_PULSE_CYCLES)
   ) u_sfd_tx (
      .clk_i(MCLK_I),
      .rstn_i(RSTN_I),
      .trig_i(SFD_TX_I),
      .active_o(sfd_tx_act)
   );

   pisd_pulse_stretch #(
      .LEN(PISD_SFD_PULSE_CYCLES)
   ) u_sfd_rx (
      .clk_i(MCLK_I),
      .rstn_i(RSTN_I),
      .trig_i(SFD_RX_I),
      .active_o(sfd_rx_act)
   );

   // Half the device clock, used by the clock output function.
   assign clk_half_next = ~clk_half_reg;

   for (genvar g = 0; g < 2; g++) begin : g_pin
      pisd_pin_func u_func (
         .func_i(func_sel[g]),
         .value_i(value_sel[g]),
         .sfd_tx_i(sfd_tx_act),
         .sfd_rx_i(sfd_rx_act),
         .link_on_i(LINK_ENABLE_I & LINK_UP_I),
         .plca_up_i(PLCA_UP_I),
         .tx_act_i(TX_ACTIVE_I),
         .rx_act_i(RX_ACTIVE_I),
         .clk_half_i(clk_half_reg),
         .drive_o(drive[g]),
         .level_o(level[g])
      );
   end

   assign pin_oe_next = drive;
   // A pin that is not driven shows zero on its data output.
   assign pin_out_next = drive & level;

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         clk_half_reg <= 1'b0;
         pin_out_reg <= 2'b00;
         pin_oe_reg <= 2'b00;
      end else begin
         clk_half_reg <= clk_half_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign PIN_OUT_O = pin_out_reg;
   assign PIN_OE_O = pin_oe_reg;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RSTN_I);

   sequence s_read_quiet;
      flags_read && (event_in == '0);
   endsequence

   sequence s_reset_cleared;
      flags_write && REG_WDATA_I[PISD_RESET_FLAG_BIT];
   endsequence

   property p_read_clears;
      s_read_quiet |=> event_flags_reg[PISD_EVT_W-1:0] == '0;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("event flags not cleared by read");

   property p_event_latches;
      (event_in != '0) |=>
         ((event_flags_reg[PISD_EVT_W-1:0] & $past(event_in))
            == $past(event_in));
   endproperty
   a_event_latches: assert property (p_event_latches)
      else $error("event did not latch its flag");

   property p_flag_holds;
      (event_flags_reg[PISD_COLLISION_BIT] && !flags_read) |=>
         event_flags_reg[PISD_COLLISION_BIT];
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("collision flag dropped without a read");

   property p_reset_value;
      $rose(RSTN_I) |-> event_flags_reg == PISD_EVENT_FLAGS_RST;
   endproperty
   a_reset_value: assert property (@(posedge MCLK_I) p_reset_value)
      else $error("flag register not at reset value");

   property p_irq_source;
      ##1 PHY_INTERRUPT_O == $past(|(event_flags_reg[PISD_EVT_W-1:0]
         & IRQ_ENABLE_I));
   endproperty
   a_irq_source: assert property (p_irq_source)
      else $error("interrupt not matching enabled flags");

   property p_reset_flag_clear;
      s_reset_cleared |=> !event_flags_reg[PISD_RESET_FLAG_BIT];
   endproperty
   a_reset_flag_clear: assert property (p_reset_flag_clear)
      else $error("reset flag not cleared by write one");

   property p_reset_flag_stays;
      !event_flags_reg[PISD_RESET_FLAG_BIT] |=>
         !event_flags_reg[PISD_RESET_FLAG_BIT] [*2];
   endproperty
   a_reset_flag_stays: assert property (p_reset_flag_stays)
      else $error("reset flag set again without reset");

   property p_disable_tristate;
      (func_sel[0] == PISD_FN_DISABLE) |=> !PIN_OE_O[0];
   endproperty
   a_disable_tristate: assert property (p_disable_tristate)
      else $error("disabled pin still driven");

   property p_gpio_value;
      (func_sel[1] == PISD_FN_GPIO) |=>
         PIN_OE_O[1] && (PIN_OUT_O[1] == $past(value_sel[1]));
   endproperty
   a_gpio_value: assert property (p_gpio_value)
      else $error("gpio pin not showing its value bit");

   property p_link_led;
      (func_sel[0] == PISD_FN_LED_LINK) |=>
         PIN_OUT_O[0] == ($past(value_sel[0])
            ~^ $past(LINK_ENABLE_I & LINK_UP_I));
   endproperty
   a_link_led: assert property (p_link_led)
      else $error("link indicator level or polarity wrong");

   property p_sfd_pulse;
      ((func_sel[0] == PISD_FN_SFD_BOTH) && value_sel[0] && SFD_RX_I
         && $stable(pin_config_reg)) ##1 $stable(pin_config_reg)
         |=> PIN_OUT_O[0];
   endproperty
   a_sfd_pulse: assert property (p_sfd_pulse)
      else $error("delimiter pulse missing on pin");

endmodule : pisd_bank

// ==== tb/pisd_host_model.sv ====
// Purpose: Host side of the register strobe port of the bank.
// Assumes: Requests launched on the falling edge, taken on the rising edge.
// Notes: Idle address and data show the inverse of the last value driven.
module pisd_host_model (
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   output logic [15:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [15:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      addr_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 16'h0000;
   end

   // ***********************************************************
   // Accesses
   // ***********************************************************
   // Inverting the released lines keeps a stale address from posing
   // as a valid one.
   task automatic write_reg(input logic [15:0] addr,
                            input logic [15:0] data);
      @(negedge clk_i);
      addr_o = addr;
      wdata_o = data;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~addr;
      wdata_o = ~data;
   endtask : write_reg

   task automatic read_reg(input logic [15:0] addr,
                           output logic [15:0] data);
      @(negedge clk_i);
      addr_o = addr;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~addr;
      data = rdata_i;
   endtask : read_reg

endmodule : pisd_host_model

// ==== tb/tb_pisd_bank.sv ====
// Purpose: Self-checking bench for the event flag and pin config bank.
// Assumes: Inputs change on the falling edge of a 50 MHz clock.
// Notes: The 25 MHz clock-out function is not compared cycle by cycle.
module tb_pisd_bank;
   import pisd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] addr, wdata, rdata, d;
   logic wr, rd, irq, sfd_tx = 1'b0, sfd_rx = 1'b0;
   logic [5:0] evt = 6'h00;
   logic [5:0] irq_en = 6'h3f;
   logic [4:0] lv = 5'h00;
   logic [1:0] oe, pout, slew, pen, pdn;
   int n_mismatch = 0;
   int n_compared = 0;

   always #10 mclk = ~mclk;

   pisd_host_model i_pisd_host_model (.clk_i(mclk), .rdata_i(rdata),
      .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

   pisd_bank i_pisd_bank (.MCLK_I(mclk), .RSTN_I(rstn), .REG_ADDR_I(addr),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
      .REG_RDATA_O(rdata), .EVT_COLLISION_I(evt[5]),
      .EVT_PLCA_RECOVERY_I(evt[4]), .EVT_REMOTE_JABBER_I(evt[3]),
      .EVT_LOCAL_JABBER_I(evt[2]), .EVT_PLCA_STATE_I(evt[1]),
      .EVT_LINK_CHANGE_I(evt[0]), .IRQ_ENABLE_I(irq_en),
      .PHY_INTERRUPT_O(irq), .SFD_TX_I(sfd_tx), .SFD_RX_I(sfd_rx),
      .LINK_ENABLE_I(lv[4]), .LINK_UP_I(lv[3]), .PLCA_UP_I(lv[2]),
      .TX_ACTIVE_I(lv[1]), .RX_ACTIVE_I(lv[0]), .PIN_OUT_O(pout),
      .PIN_OE_O(oe), .PIN_SLEW_SLOW_O(slew), .PIN_PULL_EN_O(pen),
      .PIN_PULL_DOWN_O(pdn));

   // ***********************************************************
   // Compare and report
   // ***********************************************************
   task automatic cmp_word(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp_word

   task automatic cmp_bits(input string what, input logic [1:0] exp,
                           input logic [1:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : cmp_bits

   task automatic chk_rd(input string what, input logic [15:0] a,
                         input logic [15:0] exp);
      i_pisd_host_model.read_reg(a, d);
      cmp_word(what, exp, d);
   endtask : chk_rd

   task automatic test_done;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // ***********************************************************
   // Pin expectations
   // ***********************************************************
   // Returns {drive, level}; delimiter codes are idle without a strobe.
   function automatic logic [1:0] exp_pin(logic [3:0] c, logic v);
      logic act;
      case (c)
         4'h1: return {1'b1, v};
         4'h2, 4'h3, 4'hb: act = 1'b0;
         4'h4: act = lv[4] & lv[3];
         4'h5: act = lv[2];
         4'h6: act = lv[1];
         4'h7: act = lv[0];
         4'hf: act = lv[1] | lv[0];
         default: return 2'b00;
      endcase
      return {1'b1, v ? act : ~act};
   endfunction : exp_pin

   task automatic pin_check(input logic [3:0] c, input logic v);
      logic [1:0] e1, e0;
      i_pisd_host_model.write_reg(PISD_ADDR_PIN_CONFIG,
         {3'b101, c, ~v, 3'b010, c, v});
      repeat (3) @(negedge mclk);
      e1 = exp_pin(c, ~v);
      e0 = exp_pin(c, v);
      cmp_bits("pin enable", {e1[1], e0[1]}, oe);
      cmp_bits("pin level", {e1[0], e0[0]}, pout);
      cmp_bits("slew", 2'b10, slew);
      cmp_bits("pull enable", 2'b01, pen);
      cmp_bits("pull down", 2'b10, pdn);
   endtask : pin_check

   // Counts cycles with the pin at its active level after one strobe.
   task automatic sfd_check(input logic [3:0] c, input logic v,
                            input logic tx, input logic rx,
                            input logic [15:0] exp);
      logic [15:0] n;
      n = 16'h0000;
      i_pisd_host_model.write_reg(PISD_ADDR_PIN_CONFIG, {11'h300, c, v});
      repeat (3) @(negedge mclk);
      cmp_bits("idle level", {1'b0, ~v}, {1'b0, pout[0]});
      sfd_tx = tx;
      sfd_rx = rx;
      @(negedge mclk);
      sfd_tx = 1'b0;
      sfd_rx = 1'b0;
      repeat (16) begin
         @(negedge mclk);
         if (pout[0] === v) begin
            n = n + 16'h0001;
         end
      end
      cmp_word("pulse length", exp, n);
   endtask : sfd_check

   // ***********************************************************
   // Sequence
   // ***********************************************************
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      $display("unexpected run length: limit of 20000 cycles reached");
      test_done();
   end

   initial begin
      repeat (20) @(negedge mclk);
      rstn = 1'b1;
      cmp_bits("interrupt", 2'b00, {1'b0, irq});
      cmp_bits("pull enable", 2'b11, pen);
      cmp_bits("pull down", 2'b11, pdn);
      cmp_bits("slew", 2'b00, slew);
      cmp_bits("pin enable", 2'b00, oe);
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h8000);
      cmp_bits("interrupt", 2'b00, {1'b0, irq});
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h8000);
      chk_rd("config", PISD_ADDR_PIN_CONFIG, 16'h6060);
      chk_rd("unmapped", 16'h0013, 16'h0000);
      i_pisd_host_model.write_reg(PISD_ADDR_EVENT_FLAGS, 16'h7fff);
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h8000);
      i_pisd_host_model.write_reg(PISD_ADDR_EVENT_FLAGS, 16'h8000);
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h0000);
      i_pisd_host_model.write_reg(PISD_ADDR_EVENT_FLAGS, 16'hffff);
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h0000);
      i_pisd_host_model.write_reg(PISD_ADDR_PIN_CONFIG, 16'hffff);
      chk_rd("config", PISD_ADDR_PIN_CONFIG, 16'hffff);
      $display("test reset and access finished");

      for (int i = 0; i < 6; i++) begin
         @(negedge mclk);
         evt = 6'h01 << i;
         @(negedge mclk);
         evt = 6'h00;
         repeat (2) @(negedge mclk);
         cmp_bits("interrupt", 2'b01, {1'b0, irq});
         chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h0001 << i);
         chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h0000);
         cmp_bits("interrupt", 2'b00, {1'b0, irq});
      end
      irq_en = 6'h00;
      @(negedge mclk);
      evt = 6'h3f;
      @(negedge mclk);
      evt = 6'h00;
      repeat (2) @(negedge mclk);
      cmp_bits("interrupt", 2'b00, {1'b0, irq});
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h003f);
      irq_en = 6'h3f;
      // An event in the cycle of the read must survive the clear.
      fork
         chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h0000);
         begin
            @(negedge mclk);
            evt = 6'h01;
            @(negedge mclk);
            evt = 6'h00;
         end
      join
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h0001);
      $display("test event flags finished");

      for (int p = 0; p < 2; p++) begin
         lv = p ? 5'b01101 : 5'b11010;
         for (int c = 0; c < 16; c++) begin
            if (c != 8) begin
               pin_check(c[3:0], p[0]);
            end
         end
      end
      $display("test pin functions finished");

      sfd_check(4'h2, 1'b1, 1'b1, 1'b0, 16'(PISD_SFD_PULSE_CYCLES));
      sfd_check(4'h2, 1'b1, 1'b0, 1'b1, 16'h0000);
      sfd_check(4'h3, 1'b0, 1'b0, 1'b1, 16'(PISD_SFD_PULSE_CYCLES));
      sfd_check(4'h3, 1'b1, 1'b1, 1'b0, 16'h0000);
      sfd_check(4'hb, 1'b1, 1'b0, 1'b1, 16'(PISD_SFD_PULSE_CYCLES));
      sfd_check(4'hb, 1'b0, 1'b1, 1'b0, 16'(PISD_SFD_PULSE_CYCLES));
      $display("test delimiter pulses finished");

      // A reset in mid-run must set the reset flag again.
      rstn = 1'b0;
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      chk_rd("flags", PISD_ADDR_EVENT_FLAGS, 16'h8000);
      cmp_bits("interrupt", 2'b00, {1'b0, irq});
      chk_rd("config", PISD_ADDR_PIN_CONFIG, 16'h6060);
      $display("test second reset finished");
      test_done();
   end

endmodule : tb_pisd_bank
